//--- rtl/rlc_pkg.sv
// Constants, types and field layout of the radio link configuration register bank.
// Assumes a 10 MHz system clock and a serial command port sampled by that clock.
package rlc_pkg;

  // ==========================================================================
  // Register map and command format
  // ==========================================================================
  localparam logic [4:0] ADDRESS_WIDTH_CONFIG_OFS = 5'h03;
  localparam logic [4:0] RETRANSMIT_CONFIG_OFS = 5'h04;
  localparam logic [4:0] RADIO_CHANNEL_SELECT_OFS = 5'h05;
  localparam logic [4:0] RADIO_LINK_SETUP_OFS = 5'h06;
  localparam logic [4:0] FIRST_OFS = ADDRESS_WIDTH_CONFIG_OFS;
  localparam logic [4:0] LAST_OFS = RADIO_LINK_SETUP_OFS;
  localparam int NUM_REGS = 4;

  localparam int CMD_OP_MSB = 7;
  localparam int CMD_OP_LSB = 5;
  localparam int CMD_ADDR_MSB = 4;
  localparam logic [2:0] OP_READ = 3'h0;
  localparam logic [2:0] OP_WRITE = 3'h1;

  // ==========================================================================
  // Reset values and writable bits, entry 0 is the lowest offset
  // ==========================================================================
  localparam logic [NUM_REGS-1:0][7:0] REG_RESET = {8'h0E, 8'h02, 8'h03, 8'h03};
  localparam logic [NUM_REGS-1:0][7:0] REG_WMASK = {8'hBE, 8'h7F, 8'hFF, 8'h03};

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int AW_LSB = 0;
  localparam int DELAY_LSB = 4;
  localparam int LIMIT_LSB = 0;
  localparam int CHANNEL_LSB = 0;
  localparam int CARRIER_BIT = 7;
  localparam int SLOW_BIT = 5;
  localparam int LOCK_BIT = 4;
  localparam int FAST_BIT = 3;
  localparam int PWR_LSB = 1;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_KHZ = 10000;
  localparam int RETX_STEP_US = 250;
  localparam int RETX_STEP_CYCLES = (RETX_STEP_US * CLK_KHZ + 999) / 1000;
  localparam logic [15:0] RETX_STEP = 16'(RETX_STEP_CYCLES);

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    RATE_1M = 2'b00,
    RATE_2M = 2'b01,
    RATE_250K = 2'b10
  } rlc_rate_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WRITE = 2'b01,
    ST_DONE = 2'b10
  } rlc_state_t;

  typedef struct packed {
    logic [4:0] addr_byte_mask;
    logic [2:0] addr_bytes;
    logic addr_width_ok;
    logic [15:0] retx_wait_cycles;
    logic [3:0] retx_limit;
    logic retx_enable;
    logic [6:0] channel;
    logic carrier_test;
    rlc_rate_t rate;
    logic [1:0] tx_power;
    logic force_lock;
  } rlc_settings_t;

endpackage : rlc_pkg

//--- rtl/rlc_spi_shift.sv
// Serial byte engine: synchronises the port pins and shifts bytes in and out.
// Assumes SPI mode 0 with the serial clock at most 500 kHz against the 10 MHz clock.
`timescale 1ns/10ps

module rlc_spi_shift (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_sck,
  input wire logic i_mosi,
  input wire logic i_csn_n,
  input wire logic [7:0] i_tx_byte,
  input wire logic i_tx_load,
  output logic [7:0] o_rx_byte,
  output logic o_rx_valid,
  output logic o_active,
  output logic o_miso
);

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  // Bit 0 serial clock, bit 1 data in, bit 2 select.
  localparam logic [2:0] PIN_IDLE = 3'h4;
  logic [2:0] pins;
  logic [2:0] s1;
  logic [2:0] s2;
  logic [2:0] s3;
  logic [2:0] filt;
  logic [2:0] filt_q;

  assign pins = {i_csn_n, i_mosi, i_sck};

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      always_ff @(posedge i_mclk) begin
        if (i_rst) begin
          s1[g] <= PIN_IDLE[g];
          s2[g] <= PIN_IDLE[g];
          s3[g] <= PIN_IDLE[g];
          filt[g] <= PIN_IDLE[g];
          filt_q[g] <= PIN_IDLE[g];
        end else begin
          s1[g] <= pins[g];
          s2[g] <= s1[g];
          s3[g] <= s2[g];
          // A level counts only once two later stages agree, which rejects glitches.
          filt[g] <= (s2[g] == s3[g]) ? s3[g] : filt[g];
          filt_q[g] <= filt[g];
        end
      end
    end
  endgenerate

  logic sck_rise;
  logic sck_fall;
  assign sck_rise = filt[0] & ~filt_q[0];
  assign sck_fall = ~filt[0] & filt_q[0];
  assign o_active = ~filt[2];

  // ==========================================================================
  // Receive shifter
  // ==========================================================================
  logic [2:0] bit_cnt;
  logic [7:0] rx_sh;

  always_ff @(posedge i_mclk) begin
    if (i_rst || !o_active) begin
      bit_cnt <= 3'h0;
      rx_sh <= 8'h00;
    end else if (sck_rise) begin
      bit_cnt <= bit_cnt + 3'h1;
      rx_sh <= {rx_sh[6:0], filt[1]};
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_rx_valid <= 1'b0;
      o_rx_byte <= 8'h00;
    end else begin
      o_rx_valid <= o_active && sck_rise && (bit_cnt == 3'h7);
      o_rx_byte <= (o_active && sck_rise && (bit_cnt == 3'h7)) ? {rx_sh[6:0], filt[1]} : o_rx_byte;
    end
  end

  // ==========================================================================
  // Transmit shifter
  // ==========================================================================
  // The falling edge after the eighth bit does not shift, so a freshly loaded byte keeps its MSB.
  logic [7:0] tx_sh;

  always_ff @(posedge i_mclk) begin
    if (i_rst || !o_active) begin
      tx_sh <= 8'h00;
    end else if (i_tx_load) begin
      tx_sh <= i_tx_byte;
    end else if (sck_fall && (bit_cnt != 3'h0)) begin
      tx_sh <= {tx_sh[6:0], 1'b0};
    end
  end

  assign o_miso = tx_sh[7];

endmodule : rlc_spi_shift

//--- rtl/rlc_config_regs.sv
// Radio link configuration register bank behind a serial register command port.
// Assumes a controller that frames each command with select low and keeps the
// serial clock slow enough for the 10 MHz oversampling front end.
`timescale 1ns/10ps

module rlc_config_regs (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_spi_sck,
  input wire logic i_spi_mosi,
  input wire logic i_spi_csn_n,
  output logic o_spi_miso,
  output rlc_pkg::rlc_settings_t o_settings
);

  // ==========================================================================
  // Serial front end
  // ==========================================================================
  logic [7:0] rx_byte;
  logic rx_valid;
  logic active;
  logic [7:0] tx_byte;
  logic tx_load;

  rlc_spi_shift u_shift (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_sck(i_spi_sck),
    .i_mosi(i_spi_mosi),
    .i_csn_n(i_spi_csn_n),
    .i_tx_byte(tx_byte),
    .i_tx_load(tx_load),
    .o_rx_byte(rx_byte),
    .o_rx_valid(rx_valid),
    .o_active(active),
    .o_miso(o_spi_miso)
  );

  // ==========================================================================
  // Command decode
  // ==========================================================================
  logic [2:0] rx_op;
  logic [4:0] rx_addr;
  logic rx_hit;
  logic [1:0] rx_idx;
  assign rx_op = rx_byte[rlc_pkg::CMD_OP_MSB:rlc_pkg::CMD_OP_LSB];
  assign rx_addr = rx_byte[rlc_pkg::CMD_ADDR_MSB:0];
  assign rx_hit = (rx_addr >= rlc_pkg::FIRST_OFS) && (rx_addr <= rlc_pkg::LAST_OFS);
  assign rx_idx = 2'(rx_addr - rlc_pkg::FIRST_OFS);

  rlc_pkg::rlc_state_t state;
  logic cmd_hit;
  logic [1:0] cmd_idx;

  always_ff @(posedge i_mclk) begin
    if (i_rst || !active) begin
      state <= rlc_pkg::ST_IDLE;
      cmd_hit <= 1'b0;
      cmd_idx <= 2'h0;
    end else if (rx_valid) begin
      case (state)
        rlc_pkg::ST_IDLE: begin
          cmd_hit <= rx_hit;
          cmd_idx <= rx_idx;
          state <= (rx_op == rlc_pkg::OP_WRITE) ? rlc_pkg::ST_WRITE : rlc_pkg::ST_DONE;
        end
        rlc_pkg::ST_WRITE: state <= rlc_pkg::ST_DONE;
        rlc_pkg::ST_DONE: state <= rlc_pkg::ST_DONE;
        default: state <= rlc_pkg::ST_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Register storage
  // ==========================================================================
  logic [7:0] cfg [rlc_pkg::NUM_REGS];
  logic reg_we;
  assign reg_we = rx_valid && active && (state == rlc_pkg::ST_WRITE) && cmd_hit;

  genvar g;
  generate
    for (g = 0; g < rlc_pkg::NUM_REGS; g++) begin : g_reg
      always_ff @(posedge i_mclk) begin
        if (i_rst) begin
          cfg[g] <= rlc_pkg::REG_RESET[g];
        end else if (reg_we && (cmd_idx == 2'(g))) begin
          cfg[g] <= rx_byte & rlc_pkg::REG_WMASK[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      tx_load <= 1'b0;
      tx_byte <= 8'h00;
    end else begin
      tx_load <= rx_valid && active;
      if (rx_valid && active && (state == rlc_pkg::ST_IDLE) && (rx_op == rlc_pkg::OP_READ) &&
          rx_hit) begin
        tx_byte <= cfg[rx_idx];
      end else begin
        tx_byte <= 8'h00;
      end
    end
  end

  // ==========================================================================
  // Decoded settings
  // ==========================================================================
  logic [1:0] aw_code;
  logic [3:0] delay_code;
  logic [7:0] setup;
  assign aw_code = cfg[0][rlc_pkg::AW_LSB+:2];
  assign delay_code = cfg[1][rlc_pkg::DELAY_LSB+:4];
  assign setup = cfg[3];

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_settings <= '0;
    end else begin
      case (aw_code)
        2'b01: begin
          o_settings.addr_bytes <= 3'h3;
          o_settings.addr_byte_mask <= 5'h07;
          o_settings.addr_width_ok <= 1'b1;
        end
        2'b10: begin
          o_settings.addr_bytes <= 3'h4;
          o_settings.addr_byte_mask <= 5'h0F;
          o_settings.addr_width_ok <= 1'b1;
        end
        2'b11: begin
          o_settings.addr_bytes <= 3'h5;
          o_settings.addr_byte_mask <= 5'h1F;
          o_settings.addr_width_ok <= 1'b1;
        end
        default: begin
          o_settings.addr_bytes <= 3'h0;
          o_settings.addr_byte_mask <= 5'h00;
          o_settings.addr_width_ok <= 1'b0;
        end
      endcase
      o_settings.retx_wait_cycles <= 16'(({12'h000, delay_code} + 16'h0001) * rlc_pkg::RETX_STEP);
      o_settings.retx_limit <= cfg[1][rlc_pkg::LIMIT_LSB+:4];
      o_settings.retx_enable <= (cfg[1][rlc_pkg::LIMIT_LSB+:4] != 4'h0);
      o_settings.channel <= cfg[2][rlc_pkg::CHANNEL_LSB+:7];
      o_settings.carrier_test <= setup[rlc_pkg::CARRIER_BIT];
      if (setup[rlc_pkg::SLOW_BIT]) begin
        o_settings.rate <= rlc_pkg::RATE_250K;
      end else if (setup[rlc_pkg::FAST_BIT]) begin
        o_settings.rate <= rlc_pkg::RATE_2M;
      end else begin
        o_settings.rate <= rlc_pkg::RATE_1M;
      end
      o_settings.tx_power <= setup[rlc_pkg::PWR_LSB+:2];
      o_settings.force_lock <= setup[rlc_pkg::LOCK_BIT];
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  width_decode_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (aw_code != 2'b00) |=> o_settings.addr_width_ok &&
      (o_settings.addr_bytes == 3'($past(aw_code)) + 3'h2))
    else $error("address width decode wrong");

  byte_mask_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_settings.addr_width_ok |->
      (o_settings.addr_byte_mask == 5'((6'h01 << o_settings.addr_bytes) - 6'h01)))
    else $error("address byte mask does not match width");

  retx_wait_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    1'b1 |=> (o_settings.retx_wait_cycles ==
      16'(({12'h000, $past(delay_code)} + 16'h0001) * 16'h09C4)))
    else $error("retransmit wait count wrong");

  retx_enable_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    1'b1 |=> (o_settings.retx_enable == ($past(cfg[1][3:0]) != 4'h0)))
    else $error("retransmit enable disagrees with limit");

  channel_write_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (reg_we && (cmd_idx == 2'h2)) |=> ##1 (o_settings.channel == $past(rx_byte[6:0], 2)))
    else $error("channel write did not reach setting");

  slow_rate_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    setup[rlc_pkg::SLOW_BIT] |=> (o_settings.rate == rlc_pkg::RATE_250K))
    else $error("slow rate not selected");

  setup_bits_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    1'b1 |=> (o_settings.tx_power == $past(setup[2:1])) &&
      (o_settings.carrier_test == $past(setup[7])) && (o_settings.force_lock == $past(setup[4])))
    else $error("setup fields not forwarded");

  reserved_zero_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (cfg[0][7:2] == 6'h00) && !cfg[2][7] && !cfg[3][6] && !cfg[3][0])
    else $error("reserved bit holds a one");

  hold_value_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    !reg_we |=> $stable(cfg[0]) && $stable(cfg[1]) && $stable(cfg[2]) && $stable(cfg[3]))
    else $error("register changed without a write");

  read_answer_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (rx_valid && active && (state == rlc_pkg::ST_IDLE) && (rx_op == rlc_pkg::OP_READ) && rx_hit)
      |=> tx_load && (tx_byte == $past(cfg[rx_idx])))
    else $error("read command did not load register value");

  // ==========================================================================
  // Field forwarding, storage and framing checks
  // ==========================================================================
  // The limit, channel, rate, carrier and lock settings are held against the stored byte of the cycle before
  // (the wait only against its range), so a decode of those right only for the reset values is still caught.
  width_illegal_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (aw_code == 2'b00) |=> !o_settings.addr_width_ok && (o_settings.addr_bytes == 3'h0) &&
      (o_settings.addr_byte_mask == 5'h00))
    else $error("illegal address width not flagged");

  shared_width_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    $countones(o_settings.addr_byte_mask) == 32'(o_settings.addr_bytes))
    else $error("address byte mask and width disagree");

  wait_range_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    1'b1 |=> (o_settings.retx_wait_cycles >= 16'h09C4) &&
      (o_settings.retx_wait_cycles <= 16'h9C40))
    else $error("retransmit wait out of range");

  limit_fwd_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    1'b1 |=> (o_settings.retx_limit == $past(cfg[1][3:0])))
    else $error("retransmit limit not forwarded");

  channel_fwd_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    1'b1 |=> (o_settings.channel == $past(cfg[2][6:0])))
    else $error("channel not forwarded");

  carrier_fwd_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    setup[rlc_pkg::CARRIER_BIT] |=> o_settings.carrier_test)
    else $error("carrier test bit not forwarded");

  rate_fast_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (!setup[rlc_pkg::SLOW_BIT] && setup[rlc_pkg::FAST_BIT]) |=>
      (o_settings.rate == rlc_pkg::RATE_2M))
    else $error("fast rate not selected");

  rate_base_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (!setup[rlc_pkg::SLOW_BIT] && !setup[rlc_pkg::FAST_BIT]) |=>
      (o_settings.rate == rlc_pkg::RATE_1M))
    else $error("base rate not selected");

  lock_fwd_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    setup[rlc_pkg::LOCK_BIT] |=> o_settings.force_lock)
    else $error("forced lock bit not forwarded");

  reset_regs_a: assert property (@(posedge i_mclk)
    i_rst |=> (cfg[0] == rlc_pkg::REG_RESET[0]) && (cfg[1] == rlc_pkg::REG_RESET[1]) &&
      (cfg[2] == rlc_pkg::REG_RESET[2]) && (cfg[3] == rlc_pkg::REG_RESET[3]))
    else $error("register not at its reset value");

  write_land_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    reg_we |=> (cfg[cmd_idx] == ($past(rx_byte) & rlc_pkg::REG_WMASK[cmd_idx])))
    else $error("written byte not stored under its mask");

  refused_read_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (rx_valid && active && (state == rlc_pkg::ST_IDLE) && !rx_hit) |=>
      tx_load && (tx_byte == 8'h00))
    else $error("refused address did not answer zero");

  miso_quiet_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    !active |=> !o_spi_miso)
    else $error("data out not quiet outside a frame");

  frame_idle_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    !active |=> (state == rlc_pkg::ST_IDLE) && !cmd_hit)
    else $error("command framing not cleared between frames");

endmodule : rlc_config_regs

//--- test/rlc_mcu_model.sv
// Controller model that frames serial register commands for the config bank.
// Assumes the bench calls xfer from its main sequence, off the clock's rising edge.
`timescale 1ns/10ps

module rlc_mcu_model (
  input wire logic i_mclk,
  input wire logic i_miso,
  output logic o_sck,
  output logic o_mosi,
  output logic o_csn_n
);
  // ====================================================================
  // Serial framing
  // ====================================================================
  // Each serial clock phase spans 12 system clocks, above the minimum of 10.
  localparam int HALF = 12;

  initial begin
    o_sck = 1'b0;
    o_mosi = 1'b0;
    o_csn_n = 1'b1;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge i_mclk);
  endtask : wait_clk

  task automatic shift_byte(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nbits; i--) begin
      o_mosi = tx[i];
      wait_clk(HALF);
      rx[i] = i_miso;
      o_sck = 1'b1;
      wait_clk(HALF);
      o_sck = 1'b0;
    end
  endtask : shift_byte

  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wdat, input int nbits,
                      output logic [7:0] rdat);
    logic [7:0] junk;
    o_csn_n = 1'b0;
    wait_clk(HALF);
    shift_byte(cmd, 8, junk);
    shift_byte(wdat, nbits, rdat);
    wait_clk(HALF);
    o_csn_n = 1'b1;
    // The data line is released; flipping it keeps the device from seeing a stale bit.
    o_mosi = ~o_mosi;
    wait_clk(HALF);
  endtask : xfer
endmodule : rlc_mcu_model

//--- test/tb_radio_link_config_regs.sv
// Self-checking bench for the radio link configuration register bank.
// Assumes the controller model in rlc_mcu_model and the design package rlc_pkg.
`timescale 1ns/10ps

module tb_radio_link_config_regs;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic spi_sck;
  logic spi_mosi;
  logic spi_csn_n;
  logic spi_miso;
  rlc_pkg::rlc_settings_t settings;
  int fail_count = 0;
  int n_tests = 0;
  int cycles = 0;

  always #50 i_mclk = ~i_mclk;

  rlc_config_regs dut (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_spi_sck(spi_sck),
    .i_spi_mosi(spi_mosi),
    .i_spi_csn_n(spi_csn_n),
    .o_spi_miso(spi_miso),
    .o_settings(settings)
  );

  rlc_mcu_model u_mcu (
    .i_mclk(i_mclk),
    .i_miso(spi_miso),
    .o_sck(spi_sck),
    .o_mosi(spi_mosi),
    .o_csn_n(spi_csn_n)
  );

  // ====================================================================
  // Report and helpers
  // ====================================================================
  task automatic tally_and_finish;
    if (fail_count == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // The whole run needs about 30000 cycles; the ceiling leaves ample margin.
  always @(posedge i_mclk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    logic [7:0] r;
    u_mcu.xfer({rlc_pkg::OP_WRITE, a}, v, 8, r);
  endtask : wr

  task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
    logic [7:0] r;
    u_mcu.xfer({rlc_pkg::OP_READ, a}, 8'h00, 8, r);
    chk(16'(r), 16'(exp));
  endtask : rd_chk

  // ====================================================================
  // Scenarios
  // ====================================================================
  task automatic t_reset;
    chk(16'(settings.addr_bytes), 16'h0005);
    chk(settings.retx_wait_cycles, 16'h09C4);
    chk(16'(settings.retx_limit), 16'h0003);
    chk(16'(settings.channel), 16'h0002);
    chk(16'(settings.carrier_test), 16'h0000);
    chk(16'(settings.rate), 16'(rlc_pkg::RATE_2M));
    chk(16'(settings.tx_power), 16'h0003);
    chk(16'(settings.addr_byte_mask), 16'h001F);
    chk(16'(settings.retx_enable), 16'h0001);
    chk(16'(settings.force_lock), 16'h0000);
    rd_chk(5'h03, 8'h03);
    rd_chk(5'h04, 8'h03);
    rd_chk(5'h05, 8'h02);
    rd_chk(5'h06, 8'h0E);
  endtask : t_reset

  task automatic t_width;
    logic [2:0] nb;
    for (int c = 0; c < 4; c++) begin
      nb = (c == 0) ? 3'h0 : 3'(c + 2);
      wr(5'h03, 8'hFC | 8'(c));
      rd_chk(5'h03, 8'(c));
      chk(16'(settings.addr_bytes), 16'(nb));
      chk(16'(settings.addr_byte_mask), (16'h0001 << nb) - 16'h0001);
      chk(16'(settings.addr_width_ok), 16'(c != 0));
    end
  endtask : t_width

  task automatic t_retx;
    logic [3:0][7:0] tbl = {8'h5A, 8'h0F, 8'hF0, 8'h00};
    logic [7:0] v;
    for (int k = 0; k < 4; k++) begin
      v = tbl[k];
      wr(5'h04, v);
      rd_chk(5'h04, v);
      chk(settings.retx_wait_cycles, 16'((32'(v[7:4]) + 32'h1) * 32'h9C4));
      chk(16'(settings.retx_limit), 16'(v[3:0]));
      chk(16'(settings.retx_enable), 16'(v[3:0] != 4'h0));
    end
  endtask : t_retx

  task automatic t_channel;
    wr(5'h05, 8'hFF);
    rd_chk(5'h05, 8'h7F);
    chk(16'(settings.channel), 16'h007F);
    wr(5'h05, 8'h00);
    chk(16'(settings.channel), 16'h0000);
  endtask : t_channel

  task automatic t_setup;
    logic [7:0] v;
    logic [3:0] b;
    rlc_pkg::rlc_rate_t r;
    for (int i = 0; i < 16; i++) begin
      b = 4'(i);
      v = {b[2], 1'b1, b[1], b[3], b[0], b[3:2], 1'b1};
      r = b[1] ? rlc_pkg::RATE_250K : (b[0] ? rlc_pkg::RATE_2M : rlc_pkg::RATE_1M);
      wr(5'h06, v);
      rd_chk(5'h06, v & 8'hBE);
      chk(16'(settings.rate), 16'(r));
      chk(16'(settings.tx_power), 16'(b[3:2]));
      chk(16'(settings.carrier_test), 16'(b[2]));
      chk(16'(settings.force_lock), 16'(b[3]));
    end
    wr(5'h06, 8'h0E);
  endtask : t_setup

  task automatic t_refused;
    logic [7:0] r;
    wr(5'h07, 8'h55);
    rd_chk(5'h07, 8'h00);
    wr(5'h02, 8'h55);
    rd_chk(5'h02, 8'h00);
    u_mcu.xfer({3'h2, 5'h05}, 8'h33, 8, r);
    rd_chk(5'h05, 8'h00);
    u_mcu.xfer({rlc_pkg::OP_WRITE, 5'h05}, 8'h44, 5, r);
    rd_chk(5'h05, 8'h00);
    wr(5'h05, 8'h28);
    rd_chk(5'h05, 8'h28);
    chk(16'(settings.channel), 16'h0028);
  endtask : t_refused

  task automatic t_rerst;
    i_rst = 1'b1;
    repeat (2) @(negedge i_mclk);
    chk(16'(settings.channel), 16'h0000);
    i_rst = 1'b0;
    repeat (2) @(negedge i_mclk);
    chk(16'(settings.channel), 16'h0002);
    rd_chk(5'h05, 8'h02);
    rd_chk(5'h04, 8'h03);
  endtask : t_rerst

  initial begin
    repeat (20) @(negedge i_mclk);
    i_rst = 1'b0;
    repeat (2) @(negedge i_mclk);
    t_reset();
    t_width();
    t_retx();
    t_channel();
    t_setup();
    t_refused();
    t_rerst();
    tally_and_finish();
  end
endmodule : tb_radio_link_config_regs
